// ---- hdl/dimx_map.svh ----
`ifndef DIMX_MAP_SVH
`define DIMX_MAP_SVH
// ==========================================================================
// register offsets (byte addresses on the plain register port)
`define DIMX_OFS_STATUS     8'h00
`define DIMX_OFS_IRQ_EN     8'h04
`define DIMX_OFS_IRQ_CLR    8'h08
`define DIMX_OFS_CTRL       8'h0c
`define DIMX_OFS_STATE      8'h10
// ==========================================================================
// event bit positions, shared by status, enable and clear
`define DIMX_EV_PWR_GOOD    0
`define DIMX_EV_PWR_DOWN    1
`define DIMX_EV_LOSS_SET    2
`define DIMX_EV_LOSS_CLR    3
`define DIMX_EV_WIDTH       4
// ==========================================================================
// control fields
`define DIMX_CTRL_FORCE_OFF 0
`define DIMX_CTRL_RESET     8'h00
`define DIMX_IRQ_EN_RESET   4'h0
// ==========================================================================
// timing: loss window as a time, then as whole clock cycles (rounded up)
`define DIMX_CLK_PERIOD_NS  20
`define DIMX_LOS_WINDOW_NS  200
`define DIMX_LOS_WINDOW_CYC ((`DIMX_LOS_WINDOW_NS + `DIMX_CLK_PERIOD_NS - 1) / `DIMX_CLK_PERIOD_NS)
`endif

// ---- hdl/dimx_pkg.sv ----
// ==========================================================================
// shared types of the clock mux control block
package dimx_pkg;
  // power sequencing states
  typedef enum logic [1:0] {
    PWR_WAIT_GOOD,
    PWR_RUN,
    PWR_DOWN
  } dimx_pwr_state_t;
  // decoded routing of the two reference inputs onto the banks
  typedef enum logic [1:0] {
    ROUTE_ALL_A,
    ROUTE_SPLIT,
    ROUTE_ALL_B
  } dimx_route_t;
endpackage : dimx_pkg

// ---- hdl/dimx_pwr_seq.sv ----
`timescale 1ns/100ps
// ==========================================================================
// power-good / power-down sequencer
module dimx_pwr_seq
  import dimx_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic            power_good_powerdown_n,
  output dimx_pwr_state_t      pwr_state,
  output logic                 good_pulse,
  output logic                 down_pulse
);
  dimx_pwr_state_t state_reg;   // current phase
  dimx_pwr_state_t state_next;  // phase after this edge
  logic            level_reg;   // pin level one cycle ago

  // next phase: first rise starts up, later levels steer power-down
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PWR_WAIT_GOOD: if (power_good_powerdown_n && !level_reg) state_next = PWR_RUN;  // [RQ5]
      PWR_RUN:       if (!power_good_powerdown_n) state_next = PWR_DOWN;              // [RQ6]
      PWR_DOWN:      if (power_good_powerdown_n) state_next = PWR_RUN;                // [RQ6]
      default:       state_next = PWR_WAIT_GOOD;
    endcase
  end

  // level starts low so a pin tied high still counts as the first rise
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= PWR_WAIT_GOOD;
      level_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      level_reg <= power_good_powerdown_n;
    end
  end

  assign pwr_state  = state_reg;
  assign good_pulse = (state_reg == PWR_WAIT_GOOD) && (state_next == PWR_RUN);
  assign down_pulse = (state_reg == PWR_RUN) && (state_next == PWR_DOWN);
endmodule : dimx_pwr_seq

// ---- hdl/dimx_los_det.sv ----
`timescale 1ns/100ps
// ==========================================================================
// activity monitor for one reference input
module dimx_los_det #(
  parameter int unsigned WINDOW = 10     // idle cycles before the input is called lost
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic ref_in,
  output logic      valid
);
  localparam int unsigned CW = $clog2(WINDOW + 1);
  localparam logic [CW-1:0] WIN = CW'(WINDOW);

  logic          prev_reg;   // last sampled level
  logic [CW-1:0] idle_reg;   // cycles since the last edge, saturating
  logic          edge_seen;  // level changed this cycle

  assign edge_seen = ref_in ^ prev_reg;

  // starts saturated: an input is invalid until it has been seen to toggle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      // track the pin through reset so a reference stuck high is not
      // taken for an edge at the first cycle after release
      prev_reg <= ref_in;
      idle_reg <= WIN;
    end else begin
      prev_reg <= ref_in;
      if (edge_seen) idle_reg <= '0;
      else if (idle_reg != WIN) idle_reg <= idle_reg + CW'(1);
    end
  end

  assign valid = (idle_reg != WIN);
endmodule : dimx_los_det

// ---- hdl/dimx_top.sv ----
`timescale 1ns/100ps
// Contract
// RQ1: low enable activates output, high deactivates it
// RQ2: select low/mid/high routes A-all, split, B-all
// RQ3: strap at power-up picks select or management pins
// RQ4: controller keeps strap constant after power-up
// RQ5: first rise on power pin starts device
// RQ6: afterwards pin low means power-down, high runs
// RQ7: impedance select low 85 ohm, high 100
// RQ8: open-drain loss flag low when input invalid
// RQ9: undriven inputs fall to their default levels
// RQ10: outputs map to banks per variant
// RQ11: powered-down or not started keeps outputs inactive
`include "dimx_map.svh"

// ==========================================================================
// control logic of a two-input clock multiplexer
module dimx_top
  import dimx_pkg::*;
#(
  parameter int unsigned NUM_OUTS   = 4,                     // 4 or 2 output variant
  parameter int unsigned LOS_WINDOW = `DIMX_LOS_WINDOW_CYC   // idle cycles that mean loss
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // reference inputs, sampled as ordinary synchronous levels
  input  wire logic       ref_input_a,
  input  wire logic       ref_input_b,
  // per-output enables, active low
  input  wire logic       out0_enable_n,
  input  wire logic       out1_enable_n,
  input  wire logic       out2_enable_n,
  input  wire logic       out3_enable_n,
  // three-level select: 00 low, 01 mid, 10 high, 11 floating
  input  wire logic [1:0] input_route_select,
  input  wire logic       power_good_powerdown_n,
  input  wire logic       mgmt_port_strap,
  input  wire logic       mgmt_serial_clock,
  input  wire logic       mgmt_serial_data_i,
  output logic            mgmt_serial_data_o,
  output logic            mgmt_serial_data_oe,
  input  wire logic       output_impedance_select,
  // open-drain loss flag
  input  wire logic       input_loss_flag_n_i,
  output logic            input_loss_flag_n_o,
  output logic            input_loss_flag_n_oe,
  // routed clock outputs and their status
  output logic [3:0]      out_clk,
  output logic [3:0]      out_active,
  output logic            out_impedance_100,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            irq
);

  // ========================================================================
  // helper functions

  // decode the three-level pin; the floating code lands on mid
  function automatic dimx_route_t route_decode(input logic [1:0] lvl);
    case (lvl)
      2'h0:    route_decode = ROUTE_ALL_A;   // [RQ2]
      2'h1:    route_decode = ROUTE_SPLIT;   // [RQ2]
      2'h2:    route_decode = ROUTE_ALL_B;   // [RQ2]
      default: route_decode = ROUTE_SPLIT;   // [RQ9]
    endcase
  endfunction : route_decode

  // bank of an output index; the two-output variant keeps only 1 and 2
  function automatic logic bank_of(input int unsigned idx);
    bank_of = (idx >= 2);   // [RQ10]
  endfunction : bank_of

  // whether an output index exists in this variant
  function automatic logic present(input int unsigned idx, input int unsigned outs);
    if (outs == 2) present = (idx == 1) || (idx == 2);   // [RQ10]
    else present = 1'b1;
  endfunction : present

  // ========================================================================
  // power-up strap capture

  logic strap_reg;       // latched management-port strap
  logic strap_done_reg;  // strap has been taken since reset

  // caught once on the first edge after reset release, then held; the
  // pin is ignored later because the board must keep it steady
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strap_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg      <= mgmt_port_strap;   // [RQ3] [RQ4]
      strap_done_reg <= 1'b1;
    end
  end

  // the strap decides what the shared pins mean
  wire mgmt_mode = strap_reg;

  // in management mode the shared pins carry no select or enable,
  // so both fall back to their pulled defaults
  wire [1:0] sel_level = mgmt_mode ? 2'h3 : input_route_select;     // [RQ3] [RQ9]
  wire       en3_n     = mgmt_mode ? 1'b1 : out3_enable_n;          // [RQ3] [RQ9]

  // management register map is not built; the data line stays released
  assign mgmt_serial_data_o  = 1'b0;
  assign mgmt_serial_data_oe = 1'b0;

  // ========================================================================
  // power sequencing

  dimx_pwr_state_t pwr_state;   // sequencer phase
  logic            good_pulse;  // first start-up seen this cycle
  logic            down_pulse;  // power-down entered this cycle

  dimx_pwr_seq u_pwr_seq (
    .sys_clk                (sys_clk),
    .rst_b                  (rst_b),
    .power_good_powerdown_n (power_good_powerdown_n),
    .pwr_state              (pwr_state),
    .good_pulse             (good_pulse),
    .down_pulse             (down_pulse)
  );

  // outputs may only run in normal operation
  wire running = (pwr_state == PWR_RUN);   // [RQ11]

  // ========================================================================
  // loss-of-signal monitors, one per reference input

  logic [1:0] ref_vec;    // both references as a vector
  logic [1:0] ref_valid;  // activity seen within the window

  assign ref_vec = {ref_input_b, ref_input_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_los
      dimx_los_det #(
        .WINDOW (LOS_WINDOW)
      ) u_los (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .ref_in  (ref_vec[gi]),
        .valid   (ref_valid[gi])
      );
    end
  endgenerate

  // ========================================================================
  // routing decode

  dimx_route_t route;   // current routing choice
  assign route = route_decode(sel_level);

  // source of each bank: 0 selects input A, 1 selects input B
  wire bank0_src = (route == ROUTE_ALL_B);
  wire bank1_src = (route != ROUTE_ALL_A);

  // an input counts only if some bank takes its clock
  wire a_used = (route != ROUTE_ALL_B);
  wire b_used = (route != ROUTE_ALL_A);

  // loss is any input in use without activity
  wire loss_now = (a_used && !ref_valid[0]) || (b_used && !ref_valid[1]);

  // ========================================================================
  // control register fields

  logic [7:0]              ctrl_reg;    // software control
  logic [`DIMX_EV_WIDTH-1:0] irq_en_reg;  // interrupt enables
  logic [`DIMX_EV_WIDTH-1:0] status_reg;  // sticky events
  logic [`DIMX_EV_WIDTH-1:0] status_next; // sticky events after this edge

  // software may hold every output off without touching the pins
  wire force_off = ctrl_reg[`DIMX_CTRL_FORCE_OFF];

  // ========================================================================
  // per-output enable and clock generation

  logic [3:0] en_n_vec;       // active-low enables as a vector
  logic [3:0] active_vec;     // output may toggle this cycle
  logic [3:0] out_clk_reg;    // registered routed clocks
  logic [3:0] out_active_reg; // registered active flags

  assign en_n_vec = {en3_n, out2_enable_n, out1_enable_n, out0_enable_n};

  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      // source of this output follows the bank it belongs to
      wire src = bank_of(gi) ? bank1_src : bank0_src;   // [RQ2] [RQ10]
      wire ref_sel = src ? ref_input_b : ref_input_a;

      // low enable activates; sequencer and control may veto it
      assign active_vec[gi] = present(gi, NUM_OUTS) && !en_n_vec[gi]   // [RQ1]
                              && running && !force_off;                // [RQ11]

      // an inactive output parks low instead of toggling
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          out_clk_reg[gi]    <= 1'b0;
          out_active_reg[gi] <= 1'b0;
        end else begin
          out_clk_reg[gi]    <= active_vec[gi] & ref_sel;   // [RQ1] [RQ11]
          out_active_reg[gi] <= active_vec[gi];
        end
      end
    end
  endgenerate

  assign out_clk    = out_clk_reg;
  assign out_active = out_active_reg;

  // ========================================================================
  // impedance select and loss flag, registered

  logic imp_reg;   // 1 = 100 ohm, 0 = 85 ohm
  logic loss_reg;  // loss seen, drives the flag low

  // the impedance pin defaults low, so 85 ohm after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      imp_reg  <= 1'b0;   // [RQ9]
      loss_reg <= 1'b1;
    end else begin
      imp_reg  <= output_impedance_select;   // [RQ7]
      loss_reg <= loss_now;                  // [RQ8]
    end
  end

  assign out_impedance_100 = imp_reg;

  // open drain: pull low on loss, release otherwise; the board pulls it up
  assign input_loss_flag_n_o  = 1'b0;       // [RQ8]
  assign input_loss_flag_n_oe = loss_reg;   // [RQ8]

  // ========================================================================
  // event detection

  logic loss_prev_reg;  // loss state one cycle ago

  always_ff @(posedge sys_clk) begin
    if (!rst_b) loss_prev_reg <= 1'b1;
    else loss_prev_reg <= loss_reg;
  end

  logic [`DIMX_EV_WIDTH-1:0] events;  // one-cycle event pulses
  assign events[`DIMX_EV_PWR_GOOD] = good_pulse;
  assign events[`DIMX_EV_PWR_DOWN] = down_pulse;
  assign events[`DIMX_EV_LOSS_SET] = loss_reg && !loss_prev_reg;
  assign events[`DIMX_EV_LOSS_CLR] = !loss_reg && loss_prev_reg;

  // ========================================================================
  // register port decode

  wire hit_status = (reg_addr == `DIMX_OFS_STATUS);
  wire hit_irq_en = (reg_addr == `DIMX_OFS_IRQ_EN);
  wire hit_clr    = (reg_addr == `DIMX_OFS_IRQ_CLR);
  wire hit_ctrl   = (reg_addr == `DIMX_OFS_CTRL);
  wire hit_state  = (reg_addr == `DIMX_OFS_STATE);

  wire wr_irq_en = reg_wr && hit_irq_en;
  wire wr_clr    = reg_wr && hit_clr;
  wire wr_ctrl   = reg_wr && hit_ctrl;

  // clear mask from a write to the clear register
  wire [`DIMX_EV_WIDTH-1:0] clr_mask = wr_clr ? reg_wdata[`DIMX_EV_WIDTH-1:0]
                                              : {`DIMX_EV_WIDTH{1'b0}};

  // a new event beats a clear landing in the same cycle, so none is lost
  assign status_next = (status_reg & ~clr_mask) | events;

  // ========================================================================
  // writable and sticky registers

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_reg <= {`DIMX_EV_WIDTH{1'b0}};
      irq_en_reg <= `DIMX_IRQ_EN_RESET;
      ctrl_reg   <= `DIMX_CTRL_RESET;
    end else begin
      status_reg <= status_next;
      if (wr_irq_en) irq_en_reg <= reg_wdata[`DIMX_EV_WIDTH-1:0];
      if (wr_ctrl) ctrl_reg <= reg_wdata;
    end
  end

  // ========================================================================
  // read path

  // live state: strap, phase, route, loss, pin readback, impedance
  wire [7:0] state_word = {imp_reg,
                           input_loss_flag_n_i,
                           loss_reg,
                           route,
                           pwr_state,
                           mgmt_mode};

  // unmapped and write-only addresses read as zero
  wire [7:0] rd_mux = hit_status ? {4'h0, status_reg} :
                      hit_irq_en ? {4'h0, irq_en_reg} :
                      hit_ctrl   ? ctrl_reg :
                      hit_state  ? state_word :
                                   8'h00;

  logic [7:0] rdata_reg;  // read answer, valid one cycle after the strobe

  // data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_b) rdata_reg <= 8'h00;
    else rdata_reg <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = rdata_reg;

  // ========================================================================
  // interrupt output

  logic irq_reg;  // level, high while any enabled event is pending

  always_ff @(posedge sys_clk) begin
    if (!rst_b) irq_reg <= 1'b0;
    else irq_reg <= |(status_next & irq_en_reg);
  end

  assign irq = irq_reg;

  // management clock has no consumer while the serial map is absent;
  // folding it here keeps the port documented without a floating load
  wire mgmt_unused = mgmt_serial_clock ^ mgmt_serial_data_i;

endmodule : dimx_top

// ---- tb/dimx_top_asserts.sv ----
`timescale 1ns/100ps
// ==========================================================================
// port-level checks of the clock mux control
module dimx_top_chk #(
  parameter int unsigned LOS_WINDOW = 10  // idle cycles that mean loss
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       ref_input_a,
  input wire logic       ref_input_b,
  input wire logic       out0_enable_n,
  input wire logic [1:0] input_route_select,
  input wire logic       power_good_powerdown_n,
  input wire logic       mgmt_port_strap,
  input wire logic       output_impedance_select,
  input wire logic       input_loss_flag_n_oe,
  input wire logic [3:0] out_clk,
  input wire logic [3:0] out_active,
  input wire logic       out_impedance_100,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic       first_reg;  // first edge after reset
  logic       strap_reg;  // strap as the device latched it
  logic [7:0] idle_reg;   // cycles with both refs still
  // ==========================================================================
  // mirror the strap capture and count idle reference cycles
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      first_reg <= 1'b1;
      strap_reg <= 1'b0;
      idle_reg  <= 8'h00;
    end else begin
      first_reg <= 1'b0;
      if (first_reg) begin
        strap_reg <= mgmt_port_strap;
      end
      // saturate so a long stop never wraps back to zero
      if ($changed(ref_input_a) || $changed(ref_input_b)) begin
        idle_reg <= 8'h00;
      end else if (idle_reg != 8'hff) begin
        idle_reg <= idle_reg + 8'h01;
      end
    end
  end
  // ==========================================================================
  // assertions
  a_enable_off: assert property (out0_enable_n |=> !out_active[0])
    else $error("output 0 active with enable high");
  a_pdown_idle: assert property (!power_good_powerdown_n [*2] |=> out_active == 4'h0)
    else $error("output active while powered down");
  a_route_low: assert property (!strap_reg && input_route_select == 2'b00 && $stable(input_route_select)
    ##1 out_active[2] |-> out_clk[2] == $past(ref_input_a)) else $error("low select not input a");
  a_route_high: assert property (!strap_reg && input_route_select == 2'b10 && $stable(input_route_select)
    ##1 out_active[0] |-> out_clk[0] == $past(ref_input_b)) else $error("high select not input b");
  a_route_mid: assert property (!strap_reg && input_route_select == 2'b01 ##1 (out_active[0] && out_active[2])
    |-> out_clk[0] == $past(ref_input_a) && out_clk[2] == $past(ref_input_b)) else $error("split route wrong");
  a_strap_out3: assert property (strap_reg |-> !out_active[3])
    else $error("output 3 active in management mode");
  a_loss_set: assert property (idle_reg >= LOS_WINDOW + 3 |-> input_loss_flag_n_oe)
    else $error("flag released with inputs stopped");
  a_loss_clear: assert property (($changed(ref_input_a) && $changed(ref_input_b)) [*4] |=> !input_loss_flag_n_oe)
    else $error("flag held with inputs running");
  a_imp_select: assert property (output_impedance_select [*2] |-> out_impedance_100)
    else $error("impedance select not followed");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
endmodule : dimx_top_chk

bind dimx_top dimx_top_chk #(.LOS_WINDOW(LOS_WINDOW)) u_chk (.sys_clk, .rst_b, .ref_input_a, .ref_input_b,
  .out0_enable_n, .input_route_select, .power_good_powerdown_n, .mgmt_port_strap, .output_impedance_select,
  .input_loss_flag_n_oe, .out_clk, .out_active, .out_impedance_100, .reg_rd, .reg_rdata);

// ---- tb/dimx_board.sv ----
`timescale 1ns/100ps
// ==========================================================================
// board side: reference clocks, strap and flag pull-up
module dimx_board (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic ref_run,    // references toggle while high
  input  wire logic strap_req,  // strap level wanted at power-up
  input  wire logic flag_oe,    // device pulling the flag low
  output logic      ref_a,
  output logic      ref_b,
  output logic      strap,
  output wire logic flag_wire
);
  // refs run in opposite phase so a wrong route shows at once
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ref_a <= 1'b0;
      ref_b <= 1'b1;
      strap <= strap_req;  // only moves in power-up
    end else if (ref_run) begin
      ref_a <= ~ref_a;
      ref_b <= ref_a;
    end
  end
  // open-drain flag with the pull-up that the pin needs
  assign flag_wire = flag_oe ? 1'b0 : 1'b1;
endmodule : dimx_board

// ---- tb/dimx_top_tb.sv ----
`timescale 1ns/100ps
// ==========================================================================
// self-checking bench of the clock mux control
module dimx_top_tb
  import dimx_pkg::*;
;
  localparam int unsigned LOS_W = 10;            // loss window in cycles
  localparam logic [7:0] ROUTE_EXP [4] = '{8'h00, 8'h01, 8'h02, 8'h01};
  logic       sys_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] en_n = 4'hf;                       // enables, active low
  logic [1:0] route = 2'b01;
  logic       pin = 1'b0, imp = 1'b0, ref_run = 1'b0, strap_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic       ref_a, ref_b, strap, flag_wire, flag_oe, irq, out_imp, flag_o, mgmt_o, mgmt_oe;
  logic [3:0] out_clk, out_active;
  logic [7:0] reg_rdata;
  int         err_total = 0, check_count = 0;
  always #10 sys_clk = ~sys_clk;
  dimx_board u_board (.sys_clk, .rst_b, .ref_run, .strap_req, .flag_oe, .ref_a, .ref_b, .strap, .flag_wire);
  dimx_top #(.NUM_OUTS(4), .LOS_WINDOW(LOS_W)) u_dut (
    .sys_clk, .rst_b, .ref_input_a(ref_a), .ref_input_b(ref_b),
    .out0_enable_n(en_n[0]), .out1_enable_n(en_n[1]), .out2_enable_n(en_n[2]), .out3_enable_n(en_n[3]),
    .input_route_select(route), .power_good_powerdown_n(pin), .mgmt_port_strap(strap),
    .mgmt_serial_clock(1'b0), .mgmt_serial_data_i(1'b0), .mgmt_serial_data_o(mgmt_o), .mgmt_serial_data_oe(mgmt_oe),
    .output_impedance_select(imp), .input_loss_flag_n_i(flag_wire), .input_loss_flag_n_o(flag_o),
    .input_loss_flag_n_oe(flag_oe), .out_clk, .out_active, .out_impedance_100(out_imp),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  // ==========================================================================
  // shared tasks
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // pin to state is one edge, state to outputs one more
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  task power_up(input logic s);
    @(posedge sys_clk);
    rst_b     <= 1'b0;
    strap_req <= s;
    pin       <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask : power_up
  task stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
  // ==========================================================================
  // scenarios
  initial begin
    power_up(1'b0);
    #1 chk("flag after reset", 8'h00, {7'h0, flag_wire});
    chk("released lines", 8'h00, {5'h0, flag_o, mgmt_o, mgmt_oe});
    rd(8'h04, d); chk("irq enable reset", 8'h00, d);
    rd(8'h14, d); chk("unmapped read", 8'h00, d);
    @(posedge sys_clk);
    ref_run <= 1'b1;
    en_n    <= 4'h0;
    wr(8'h04, 8'h01);
    settle; chk("active before start", 8'h00, {4'h0, out_active});
    chk("flag running", 8'h01, {7'h0, flag_wire});
    chk("irq before start", 8'h00, {7'h0, irq});
    @(posedge sys_clk);
    pin <= 1'b1;
    settle; chk("active at start", 8'h0f, {4'h0, out_active});
    chk("irq at start", 8'h01, {7'h0, irq});
    rd(8'h00, d); chk("start event", 8'h01, d & 8'h01);
    @(posedge sys_clk);
    en_n <= 4'h3;
    settle; chk("two enables high", 8'h0c, {4'h0, out_active});
    @(posedge sys_clk);
    en_n <= 4'h2;
    settle; chk("one enable high", 8'h0d, {4'h0, out_active});
    // software force-off overrides the pins
    wr(8'h0c, 8'h01);
    settle; chk("forced off", 8'h00, {4'h0, out_active});
    rd(8'h0c, d); chk("ctrl readback", 8'h01, d);
    wr(8'h0c, 8'h00);
    // every select level, floating last
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      route <= i[1:0];
      settle;
      rd(8'h10, d); chk("route state", ROUTE_EXP[i], {6'h0, d[4:3]});
    end
    @(posedge sys_clk);
    imp <= 1'b1;
    settle; chk("impedance out", 8'h01, {7'h0, out_imp});
    rd(8'h10, d); chk("impedance state", 8'h01, {7'h0, d[7]});
    wr(8'h08, 8'h0f);
    settle; chk("irq cleared", 8'h00, {7'h0, irq});
    rd(8'h00, d); chk("status cleared", 8'h00, d);
    // power-down with its interrupt masked first
    wr(8'h04, 8'h01);
    @(posedge sys_clk);
    pin <= 1'b0;
    settle; chk("active in power-down", 8'h00, {4'h0, out_active});
    chk("masked irq", 8'h00, {7'h0, irq});
    rd(8'h00, d); chk("power-down event", 8'h02, d);
    wr(8'h04, 8'h02);
    settle; chk("unmasked irq", 8'h01, {7'h0, irq});
    wr(8'h08, 8'h02);
    settle; chk("irq after clear", 8'h00, {7'h0, irq});
    @(posedge sys_clk);
    pin <= 1'b1;
    settle; chk("active after wake", 8'h0d, {4'h0, out_active});
    rd(8'h00, d); chk("no second start", 8'h00, d);
    rd(8'h10, d); chk("run state", 8'h01, {6'h0, d[2:1]});
    // stop both references until loss shows
    @(posedge sys_clk);
    ref_run <= 1'b0;
    repeat (LOS_W + 4) @(posedge sys_clk);
    #1 chk("flag on loss", 8'h00, {7'h0, flag_wire});
    rd(8'h00, d); chk("loss event", 8'h04, d & 8'h04);
    @(posedge sys_clk);
    ref_run <= 1'b1;
    settle; chk("flag restored", 8'h01, {7'h0, flag_wire});
    // second power-up in management mode
    power_up(1'b1);
    @(posedge sys_clk);
    pin   <= 1'b1;
    route <= 2'b00;
    en_n  <= 4'h0;
    settle; chk("management outputs", 8'h07, {4'h0, out_active});
    rd(8'h10, d); chk("management state", 8'h03, {5'h0, d[4:3], d[0]});
    stop_test();
  end
endmodule : dimx_top_tb
